// ===== ndu_chk_assertions.sv
// Purpose: port-level checks of the divide unit datapath
// Assumes: ACC_W of 32, single clock domain
// Notes: bound into every unit instance
`timescale 1ns/1ns
module ndu_chk
  import ndu_pkg::*;
#(
  parameter int ACC_W = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire ndu_func_type arith_function_field,
  input wire logic [ACC_W-1:0] operand_bus_r,
  input wire logic [ACC_W-1:0] accum_high,
  input wire logic [ACC_W-1:0] accum_low,
  input wire logic [ACC_W-1:0] write_bus,
  input wire logic next_op_flag,
  input wire logic shift_out_flag,
  input wire logic alu_link_carry,
  input wire logic loop_flag,
  input wire logic [1:0] alu_state_latch
);
  // function decode and expected alu sums
  wire ndu_func_type f = arith_function_field;
  wire dv = f inside {fn_fast_div_pos, fn_fast_div_neg, fn_slow_div_pos, fn_slow_div_neg};
  wire ng = f inside {fn_fast_div_neg, fn_slow_div_neg};
  wire [32:0] mg = {1'b0, ng ? -operand_bus_r : operand_bus_r};
  wire [33:0] su = {2'h0, accum_high} + {1'b0, ~mg} + 34'h1;
  wire [31:0] rd = accum_high - operand_bus_r;
  wire [32:0] sa = {1'b0, accum_high} + {1'b0, operand_bus_r} + 33'(alu_link_carry);
  wire [32:0] sb = {1'b0, accum_high} + {1'b0, ~operand_bus_r} + 33'(!alu_link_carry);

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_setup_shift:
    assert property (dv && !loop_flag |=> accum_high == {$past(su[30:0]), $past(accum_low[31])}
      && accum_low == {$past(accum_low[30:0]), $past(su[33])} && shift_out_flag == $past(su[31]))
    else $error("setup shift wrong");
  chk_setup_tog:
    assert property (dv && !loop_flag |=> next_op_flag == $past(su[33]) && loop_flag)
    else $error("setup flags wrong");
  chk_loop_hold:
    assert property (loop_flag && (dv || f inside {fn_dbl_div_add, fn_dbl_div_sub, fn_multiply,
      fn_wb_add, fn_wb_sub}) |=> loop_flag) else $error("loop dropped");
  chk_loop_clear:
    assert property ($fell(loop_flag) |-> $past(f) inside {fn_nop, fn_pass, fn_remainder_unshift})
    else $error("loop cleared wrongly");
  chk_iter_carry:
    assert property (dv && loop_flag |=> alu_state_latch[1] == next_op_flag
      && next_op_flag == accum_low[0]) else $error("iteration carry wrong");
  chk_slow_shift:
    assert property (loop_flag && f inside {fn_slow_div_pos, fn_slow_div_neg}
      |=> accum_low[31:1] == $past(accum_low[30:0])) else $error("slow shift wrong");
  chk_fast_shift:
    assert property (loop_flag && f inside {fn_fast_div_pos, fn_fast_div_neg}
      |=> accum_low[31:2] == $past(accum_low[29:0])) else $error("fast shift wrong");
  chk_rem_shift:
    assert property (f == fn_remainder_unshift |=> accum_high == {$past(shift_out_flag),
      $past(rd[31:1])} && shift_out_flag == $past(rd[0])) else $error("unshift wrong");
  chk_dbl_add:
    assert property (f == fn_dbl_div_add |=> accum_high == {$past(sa[30:0]),
      $past(alu_link_carry)} && accum_low[0] == $past(sa[32])) else $error("dbl add wrong");
  chk_dbl_sub:
    assert property (f == fn_dbl_div_sub |=> accum_high == {$past(sb[30:0]),
      $past(alu_link_carry)} && accum_low[0] == $past(sb[32])) else $error("dbl sub wrong");
  chk_dbl_keep:
    assert property (f inside {fn_dbl_div_add, fn_dbl_div_sub} |=> $stable(alu_link_carry)
      && $stable(shift_out_flag) && write_bus == accum_high) else $error("dbl side wrong");
endmodule // ndu_chk

bind ndu_divide_unit ndu_chk #(.ACC_W(ACC_W)) i_chk (.aclk, .aresetn, .arith_function_field,
  .operand_bus_r, .accum_high, .accum_low, .write_bus, .next_op_flag, .shift_out_flag,
  .alu_link_carry, .loop_flag, .alu_state_latch);

// ===== ndu_div_step.sv
// Purpose: one nonrestoring divide iteration on the partial remainder
// Assumes: mag is the divisor magnitude, tog_in high means subtract
// Notes: purely combinational, chained twice for the fast variant
`timescale 1ns/1ns
module ndu_div_step #(
  parameter int W = 32
) (
  input wire logic [W-1:0] d_in,
  input wire logic [W-1:0] q_in,
  input wire logic so_in,
  input wire logic tog_in,
  input wire logic [W-1:0] mag,
  output logic [W-1:0] d_out,
  output logic [W-1:0] q_out,
  output logic so_out,
  output logic carry_out
);

  logic [W+1:0] ext;
  logic [W+1:0] opnd;
  logic [W+1:0] sum;

  // partial remainder extended by the shift-out bit, add or subtract magnitude
  assign ext = {1'b0, so_in, d_in};
  assign opnd = tog_in ? {1'b0, ~{1'b0, mag}} : {2'b00, mag};
  assign sum = ext + opnd + {{(W+1){1'b0}}, tog_in};

  // carry out marks a non-negative result, i.e. a successful compare
  assign carry_out = sum[W+1];
  assign so_out = sum[W-1];
  assign d_out = {sum[W-2:0], q_in[W-1]}; // shift-in from quotient msb
  assign q_out = {q_in[W-2:0], sum[W+1]}; // new quotient bit

endmodule // ndu_div_step

// ===== ndu_divide_unit.sv
// Purpose: divide part of the arithmetic unit, stepped by the microsequencer
// Assumes: one microcycle per aclk, function field and operand synchronous to aclk
// Notes: control bus writes wait until the function field is fn_nop
//
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
module ndu_divide_unit
  import ndu_pkg::*;
#(
  parameter int ACC_W = NDU_ACC_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire ndu_func_type arith_function_field,
  input wire logic [ACC_W-1:0] operand_bus_r,
  output logic [ACC_W-1:0] accum_high,
  output logic [ACC_W-1:0] accum_low,
  output logic [ACC_W-1:0] write_bus,
  output logic next_op_flag,
  output logic shift_out_flag,
  output logic alu_link_carry,
  output logic loop_flag,
  output logic [1:0] alu_state_latch,
  input wire logic [NDU_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [NDU_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [NDU_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [NDU_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // refuse widths the datapath or the 32-bit register words cannot hold
  generate
    if (ACC_W < 2 || ACC_W > NDU_DATA_W) begin : g_bad_width
      $error("ndu_divide_unit: ACC_W must lie between 2 and 32");
    end
  endgenerate

  // byte-lane merge of a register word
  function automatic logic [NDU_DATA_W-1:0] ndu_merge(
    input logic [NDU_DATA_W-1:0] old_val,
    input logic [NDU_DATA_W-1:0] new_val,
    input logic [3:0] strb
  );
    logic [NDU_DATA_W-1:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_val[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // datapath state
  logic [ACC_W-1:0] acc_high_r, acc_high_nxt;
  logic [ACC_W-1:0] acc_low_r, acc_low_nxt;
  logic [ACC_W-1:0] write_bus_r, write_bus_nxt;
  logic tog_r, tog_nxt;
  logic so_r, so_nxt;
  logic alu_link_carry_r, alu_link_carry_nxt;
  logic loop_r, loop_nxt;
  logic state_carry_r, state_carry_nxt;

  // bus slave state
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [NDU_ADDR_W-1:0] aw_addr_r, ar_addr_r;
  logic [NDU_DATA_W-1:0] w_data_r, rdata_r;
  logic [3:0] w_strb_r;
  logic aw_held_r, w_held_r, ar_held_r;

  // function decode
  wire ndu_func_type fn = arith_function_field;
  wire div_sel = ndu_is_loop_div(fn);
  wire div_neg = ndu_is_div_neg(fn);
  wire setup = div_sel & ~loop_r;
  wire two_iter = div_sel & ~setup & ndu_is_fast(fn);

  // divisor magnitude; the sign came from the function chosen by the sequencer
  wire [ACC_W-1:0] div_mag = div_neg ? (~operand_bus_r + {{(ACC_W-1){1'b0}}, 1'b1})
                                     : operand_bus_r;

  // iteration chain, stage 0 feeds stage 1
  logic [ACC_W-1:0] st_d [0:2];
  logic [ACC_W-1:0] st_q [0:2];
  logic st_so [0:2];
  logic st_tog [0:2];

  // set-up forces a compare, i.e. subtract the magnitude from a clean top
  assign st_d[0] = acc_high_r;
  assign st_q[0] = acc_low_r;
  assign st_so[0] = setup ? 1'b0 : so_r;
  assign st_tog[0] = setup ? 1'b1 : tog_r;

  // both variants run the same iteration, only the count per cycle differs
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_step
      ndu_div_step #(
        .W(ACC_W)
      ) u_step (
        .d_in(st_d[g]),
        .q_in(st_q[g]),
        .so_in(st_so[g]),
        .tog_in(st_tog[g]),
        .mag(div_mag),
        .d_out(st_d[g+1]),
        .q_out(st_q[g+1]),
        .so_out(st_so[g+1]),
        .carry_out(st_tog[g+1])
      );
    end
  endgenerate

  // selected iteration result
  wire [ACC_W-1:0] it_d = two_iter ? st_d[2] : st_d[1];
  wire [ACC_W-1:0] it_q = two_iter ? st_q[2] : st_q[1];
  wire it_so = two_iter ? st_so[2] : st_so[1];
  wire it_carry = two_iter ? st_tog[2] : st_tog[1];

  // remainder unshift: accum_high minus operand, which the sequencer holds at zero
  wire [ACC_W-1:0] rem_alu = acc_high_r - operand_bus_r;
  wire [ACC_W-1:0] rem_d = {so_r, rem_alu[ACC_W-1:1]};

  // double precision step: add or subtract operand and link carry
  wire dbl_sub = (fn == fn_dbl_div_sub);
  wire [ACC_W:0] dbl_sum = dbl_sub ?
      ({1'b0, acc_high_r} + {1'b0, ~operand_bus_r} + {{ACC_W{1'b0}}, ~alu_link_carry_r}) :
      ({1'b0, acc_high_r} + {1'b0, operand_bus_r} + {{ACC_W{1'b0}}, alu_link_carry_r});
  wire [ACC_W-1:0] dbl_d = {dbl_sum[ACC_W-2:0], alu_link_carry_r};
  wire [ACC_W-1:0] dbl_q = {acc_low_r[ACC_W-2:0], dbl_sum[ACC_W]};

  // write-bus alu functions used for remainder restore
  wire [ACC_W-1:0] wb_sum = (fn == fn_wb_sub) ? (acc_high_r - operand_bus_r)
                                              : (acc_high_r + operand_bus_r);

  // bus write decode; a write lands only while the datapath is idle
  wire fn_idle = (fn == fn_nop);
  wire do_write = aw_held_r & w_held_r & ~bvalid_r & fn_idle;
  wire wr_high = (aw_addr_r[NDU_ADDR_W-1:2] == NDU_OFS_ACC_HIGH[NDU_ADDR_W-1:2]);
  wire wr_low = (aw_addr_r[NDU_ADDR_W-1:2] == NDU_OFS_ACC_LOW[NDU_ADDR_W-1:2]);
  wire wr_flags = (aw_addr_r[NDU_ADDR_W-1:2] == NDU_OFS_FLAGS[NDU_ADDR_W-1:2]);
  wire wr_ro = (aw_addr_r[NDU_ADDR_W-1:2] == NDU_OFS_WRITE_BUS[NDU_ADDR_W-1:2]) ||
               (aw_addr_r[NDU_ADDR_W-1:2] == NDU_OFS_FUNC[NDU_ADDR_W-1:2]);
  wire wr_hit = wr_high | wr_low | wr_flags | wr_ro;

  // current register words as seen by the bus
  wire [NDU_DATA_W-1:0] flags_word = NDU_DATA_W'({state_carry_r, loop_r, alu_link_carry_r, so_r, tog_r});
  wire [NDU_DATA_W-1:0] high_word = NDU_DATA_W'(acc_high_r);
  wire [NDU_DATA_W-1:0] low_word = NDU_DATA_W'(acc_low_r);
  wire [NDU_DATA_W-1:0] write_bus_word = NDU_DATA_W'(write_bus_r);
  wire [NDU_DATA_W-1:0] func_word = NDU_DATA_W'(fn);
  wire [NDU_DATA_W-1:0] high_merge = ndu_merge(high_word, w_data_r, w_strb_r);
  wire [NDU_DATA_W-1:0] low_merge = ndu_merge(low_word, w_data_r, w_strb_r);
  wire [NDU_DATA_W-1:0] flags_merge = ndu_merge(flags_word, w_data_r, w_strb_r);

  // datapath next state per function
  always_comb begin
    acc_high_nxt = acc_high_r;
    acc_low_nxt = acc_low_r;
    write_bus_nxt = write_bus_r;
    tog_nxt = tog_r;
    so_nxt = so_r;
    alu_link_carry_nxt = alu_link_carry_r;
    state_carry_nxt = state_carry_r;
    // only functions outside the loop group clear the loop flag
    loop_nxt = ndu_keeps_loop(fn) ? loop_r : 1'b0;
    case (fn)
      // flow lasts while a divide function stays selected
      fn_fast_div_pos, fn_fast_div_neg, fn_slow_div_pos, fn_slow_div_neg: begin
        // shifted left, quotient bit into accum_low
        acc_high_nxt = it_d;
        acc_low_nxt = it_q;
        so_nxt = it_so;
        // result kept for the next iteration
        tog_nxt = it_carry;
        // last carry stays in the state latch
        state_carry_nxt = it_carry;
        if (setup) begin
          loop_nxt = 1'b1;
        end
      end
      fn_remainder_unshift: begin
        acc_high_nxt = rem_d;
        so_nxt = rem_alu[0];
      end
      fn_dbl_div_add, fn_dbl_div_sub: begin
        acc_high_nxt = dbl_d;
        acc_low_nxt = dbl_q;
        write_bus_nxt = dbl_d;
        alu_link_carry_nxt = alu_link_carry_r;
        so_nxt = so_r;
      end
      fn_wb_add, fn_wb_sub: begin
        // restore leaves remainder magnitude in accum_high
        acc_high_nxt = wb_sum;
        write_bus_nxt = wb_sum;
      end
      default: begin
        // idle or unsupported: hold, bus writes may land
        if (do_write && wr_high) begin
          acc_high_nxt = high_merge[ACC_W-1:0];
        end
        if (do_write && wr_low) begin
          acc_low_nxt = low_merge[ACC_W-1:0];
        end
        if (do_write && wr_flags) begin
          tog_nxt = flags_merge[NDU_FLG_NEXT_OP];
          so_nxt = flags_merge[NDU_FLG_SHIFT_OUT];
          alu_link_carry_nxt = flags_merge[NDU_FLG_LINK_CARRY];
          state_carry_nxt = flags_merge[NDU_FLG_STATE_CARRY];
        end
      end
    endcase
  end

  // datapath registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_high_r <= '0;
      acc_low_r <= '0;
      write_bus_r <= '0;
      tog_r <= NDU_RST_FLAG;
      so_r <= NDU_RST_FLAG;
      alu_link_carry_r <= NDU_RST_FLAG;
      loop_r <= NDU_RST_FLAG;
      state_carry_r <= NDU_RST_FLAG;
    end else begin
      acc_high_r <= acc_high_nxt;
      acc_low_r <= acc_low_nxt;
      write_bus_r <= write_bus_nxt;
      tog_r <= tog_nxt;
      so_r <= so_nxt;
      alu_link_carry_r <= alu_link_carry_nxt;
      loop_r <= loop_nxt;
      state_carry_r <= state_carry_nxt;
    end
  end

  // write address and data channels, taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= NDU_RST_READY;
      wready_r <= NDU_RST_READY;
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= '0;
      w_strb_r <= '0;
    end else if (do_write) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
    end else begin
      if (s_axi_awvalid && awready_r) begin
        aw_addr_r <= s_axi_awaddr;
        aw_held_r <= 1'b1;
        awready_r <= 1'b0;
      end
      if (s_axi_wvalid && wready_r) begin
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        w_held_r <= 1'b1;
        wready_r <= 1'b0;
      end
    end
  end

  // write response, unmapped addresses answer slave error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= NDU_RESP_OKAY;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_hit ? NDU_RESP_OKAY : NDU_RESP_SLVERR;
    end else if (s_axi_bready && bvalid_r) begin
      bvalid_r <= 1'b0;
    end
  end

  // read decode
  wire [NDU_ADDR_W-3:0] rd_idx = ar_addr_r[NDU_ADDR_W-1:2];
  wire rd_high = (rd_idx == NDU_OFS_ACC_HIGH[NDU_ADDR_W-1:2]);
  wire rd_low = (rd_idx == NDU_OFS_ACC_LOW[NDU_ADDR_W-1:2]);
  wire rd_flags = (rd_idx == NDU_OFS_FLAGS[NDU_ADDR_W-1:2]);
  wire rd_write_bus = (rd_idx == NDU_OFS_WRITE_BUS[NDU_ADDR_W-1:2]);
  wire rd_func = (rd_idx == NDU_OFS_FUNC[NDU_ADDR_W-1:2]);
  wire rd_hit = rd_high | rd_low | rd_flags | rd_write_bus | rd_func;
  wire [NDU_DATA_W-1:0] rd_word = rd_high ? high_word :
                                  rd_low ? low_word :
                                  rd_flags ? flags_word :
                                  rd_write_bus ? write_bus_word :
                                  rd_func ? func_word : '0;

  // read channel: address taken, data one cycle later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= NDU_RST_READY;
      ar_held_r <= 1'b0;
      ar_addr_r <= '0;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= NDU_RESP_OKAY;
    end else if (ar_held_r) begin
      ar_held_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rd_word;
      rresp_r <= rd_hit ? NDU_RESP_OKAY : NDU_RESP_SLVERR;
    end else if (rvalid_r) begin
      if (s_axi_rready) begin
        rvalid_r <= 1'b0;
        arready_r <= 1'b1;
      end
    end else if (s_axi_arvalid && arready_r) begin
      ar_addr_r <= s_axi_araddr;
      ar_held_r <= 1'b1;
      arready_r <= 1'b0;
    end
  end

  // outputs straight from registers, except alu_state_latch bit 0, tied to its reset value
  assign accum_high = acc_high_r;
  assign accum_low = acc_low_r;
  assign write_bus = write_bus_r;
  assign next_op_flag = tog_r;
  assign shift_out_flag = so_r;
  assign alu_link_carry = alu_link_carry_r;
  assign loop_flag = loop_r;
  assign alu_state_latch = {state_carry_r, NDU_RST_STATE_LATCH[0]};
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

endmodule // ndu_divide_unit

// ===== ndu_pkg.sv
// Purpose: shared constants, function codes and decode helpers of the divide unit
// Assumes: 32-bit register words on the control bus, byte addressing
// Notes: register offsets are byte addresses of aligned words
package ndu_pkg;

  // arithmetic function field values issued by the microsequencer
  typedef enum logic [3:0] {
    fn_nop,
    fn_fast_div_pos,
    fn_fast_div_neg,
    fn_slow_div_pos,
    fn_slow_div_neg,
    fn_remainder_unshift,
    fn_dbl_div_add,
    fn_dbl_div_sub,
    fn_wb_add,
    fn_wb_sub,
    fn_multiply,
    fn_pass
  } ndu_func_type;

  // datapath and bus widths
  localparam int NDU_ACC_W = 32;
  localparam int NDU_ADDR_W = 8;
  localparam int NDU_DATA_W = 32;

  // register byte offsets
  localparam logic [NDU_ADDR_W-1:0] NDU_OFS_ACC_HIGH = 8'h00;
  localparam logic [NDU_ADDR_W-1:0] NDU_OFS_ACC_LOW = 8'h04;
  localparam logic [NDU_ADDR_W-1:0] NDU_OFS_FLAGS = 8'h08;
  localparam logic [NDU_ADDR_W-1:0] NDU_OFS_WRITE_BUS = 8'h0c;
  localparam logic [NDU_ADDR_W-1:0] NDU_OFS_FUNC = 8'h10;

  // bit positions inside the flags register
  localparam int NDU_FLG_NEXT_OP = 0;
  localparam int NDU_FLG_SHIFT_OUT = 1;
  localparam int NDU_FLG_LINK_CARRY = 2;
  localparam int NDU_FLG_LOOP = 3;
  localparam int NDU_FLG_STATE_CARRY = 4;

  // bit of the alu state latch that keeps the final carry
  localparam int NDU_ASL_CARRY_BIT = 1;

  // values after reset
  localparam logic NDU_RST_FLAG = 1'b0;
  localparam logic [1:0] NDU_RST_STATE_LATCH = 2'h0;
  localparam logic NDU_RST_READY = 1'b1;

  // bus responses
  localparam logic [1:0] NDU_RESP_OKAY = 2'h0;
  localparam logic [1:0] NDU_RESP_SLVERR = 2'h2;

  // one of the four looping divide functions
  function automatic logic ndu_is_loop_div(input ndu_func_type f);
    return (f == fn_fast_div_pos) || (f == fn_fast_div_neg) ||
           (f == fn_slow_div_pos) || (f == fn_slow_div_neg);
  endfunction

  // divisor treated as negative
  function automatic logic ndu_is_div_neg(input ndu_func_type f);
    return (f == fn_fast_div_neg) || (f == fn_slow_div_neg);
  endfunction

  // two iterations per microcycle
  function automatic logic ndu_is_fast(input ndu_func_type f);
    return (f == fn_fast_div_pos) || (f == fn_fast_div_neg);
  endfunction

  // functions under which the loop flag survives
  function automatic logic ndu_keeps_loop(input ndu_func_type f);
    return ndu_is_loop_div(f) || (f == fn_dbl_div_add) || (f == fn_dbl_div_sub) ||
           (f == fn_multiply) || (f == fn_wb_add) || (f == fn_wb_sub);
  endfunction

endpackage

// ===== ndu_seq_model.sv
// Purpose: microsequencer stand-in running divide flows
// Assumes: dividend already loaded in the accumulators
// Notes: passes the bench function through while idle
`timescale 1ns/1ns
module ndu_seq_model
  import ndu_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire logic fast,
  input wire logic neg,
  input wire logic lazy,
  input wire logic [31:0] divisor,
  input wire logic fin_carry,
  input wire ndu_func_type man_fn,
  input wire logic [31:0] man_op,
  output ndu_func_type fn,
  output logic [31:0] op,
  output logic busy
);
  logic [2:0] ph_r;
  logic [5:0] step_r;
  assign fn = ph_r == 3'h1 ? (fast ? (neg ? fn_fast_div_neg : fn_fast_div_pos)
    : (neg ? fn_slow_div_neg : fn_slow_div_pos)) : ph_r == 3'h2 ? fn_remainder_unshift
    : ph_r == 3'h3 ? fn_pass : ph_r == 3'h4 ? (neg ? fn_wb_sub : fn_wb_add) : man_fn;
  assign op = ph_r == 3'h2 ? 32'h0 : ph_r == 3'h0 ? man_op : divisor;
  assign busy = ph_r != 3'h0;
  // step counter, restore only on failed compare
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ph_r <= 3'h0;
    end else if (ph_r == 3'h0 && start) begin
      ph_r <= 3'h1;
      step_r <= fast ? 6'h11 : 6'h21;
    end else if (ph_r == 3'h1) begin
      step_r <= step_r - 6'h1;
      if (step_r == 6'h1) ph_r <= 3'h2;
    end else if (ph_r == 3'h2) begin
      ph_r <= fin_carry ? 3'h0 : (lazy ? 3'h3 : 3'h4);
    end else if (ph_r != 3'h0) begin
      ph_r <= ph_r == 3'h3 ? 3'h4 : 3'h0;
    end
  end
endmodule // ndu_seq_model

// ===== nonrestoring_divide_unit_tb.sv
// Purpose: self-checking bench of the divide unit
// Assumes: bus writes only while the field is fn_nop
// Notes: expected values from integer division and sums
`timescale 1ns/1ns
module nonrestoring_divide_unit_tb;
  import ndu_pkg::*;
  logic aclk, aresetn, start, fast, neg, lazy, busy;
  logic [31:0] dvs, man_op, operand_bus_r, accum_high, accum_low, write_bus;
  ndu_func_type man_fn, arith_function_field;
  logic next_op_flag, shift_out_flag, alu_link_carry, loop_flag;
  logic [1:0] alu_state_latch, s_axi_bresp, s_axi_rresp, r;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, dd, dr, dl, d;
  logic [3:0] s_axi_wstrb;
  logic [32:0] sm;
  int error_cnt, total_checks, n;

  ndu_divide_unit i_dut (.aclk, .aresetn, .arith_function_field, .operand_bus_r, .accum_high,
    .accum_low, .write_bus, .next_op_flag, .shift_out_flag, .alu_link_carry, .loop_flag,
    .alu_state_latch, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  ndu_seq_model i_seq (.aclk, .aresetn, .start, .fast, .neg, .lazy, .divisor(dvs),
    .fin_carry(alu_state_latch[1]), .man_fn, .man_op, .fn(arith_function_field),
    .op(operand_bus_r), .busy);

  // microcycle clock
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic hang();
    error_cnt++;
    $display("mismatch wait expected answer seen timeout");
    tally_and_finish();
  endtask

  // one write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      r = s_axi_bresp;
    end while (!s_axi_bvalid && n < 200);
    if (!s_axi_bvalid) hang();
    s_axi_bready <= 1'b0;
  endtask

  // one read
  task automatic rd(input logic [7:0] a);
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      d = s_axi_rdata;
      r = s_axi_rresp;
    end while (!s_axi_rvalid && n < 200);
    if (!s_axi_rvalid) hang();
    s_axi_rready <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk($sformatf("reg %h", a), e, d);
    chk("rresp", {30'h0, NDU_RESP_OKAY}, {30'h0, r});
  endtask

  initial begin
    {aresetn, start, fast, neg, lazy, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 8'h0;
    {s_axi_arvalid, s_axi_rready, dvs, man_op, s_axi_wdata} = 98'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 20'h0000f;
    man_fn = fn_nop;
    error_cnt = 0;
    total_checks = 0;
    d = $urandom(43);
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values, read-only places, unmapped address
    for (int i = 0; i < 5; i++) rchk(8'(i * 4), 32'h0);
    wr(NDU_OFS_FLAGS, 32'hff);
    rchk(NDU_OFS_FLAGS, 32'h17);
    wr(NDU_OFS_WRITE_BUS, 32'h5a);
    rchk(NDU_OFS_WRITE_BUS, 32'h0);
    wr(8'h14, 32'h1);
    chk("bresp", {30'h0, NDU_RESP_SLVERR}, {30'h0, r});
    rd(8'h14);
    chk("rresp", {30'h0, NDU_RESP_SLVERR}, {30'h0, r});
    chk("rdata", 32'h0, d);
    $display("test registers done");
    // full divide flows in all four variants
    for (int i = 0; i < 16; i++) begin
      dd = $urandom;
      dr = $urandom & 32'h7fffffff;
      if (i == 0) dr = 32'h1;
      if (i == 5) dr = 32'h7fffffff;
      if (dr == 32'h0) dr = 32'h3;
      if (i == 10) dd = dr - 32'h1;
      wr(NDU_OFS_ACC_HIGH, 32'h0);
      wr(NDU_OFS_ACC_LOW, dd);
      wr(NDU_OFS_FLAGS, 32'h0);
      @(posedge aclk);
      fast <= i[0];
      neg <= i[1];
      lazy <= 1'($urandom);
      dvs <= i[1] ? -dr : dr;
      start <= 1'b1;
      @(posedge aclk);
      start <= 1'b0;
      n = 0;
      do begin
        @(posedge aclk);
        n++;
      end while (busy && n < 100);
      if (busy) hang();
      rchk(NDU_OFS_ACC_LOW, dd / dr);
      rchk(NDU_OFS_ACC_HIGH, dd % dr);
    end
    $display("test divide done");
    // double precision steps, add and subtract
    for (int i = 0; i < 8; i++) begin
      dd = $urandom;
      dl = $urandom;
      dr = $urandom;
      wr(NDU_OFS_ACC_HIGH, dd);
      wr(NDU_OFS_ACC_LOW, dl);
      wr(NDU_OFS_FLAGS, 32'(i[1:0]) << 1);
      @(posedge aclk);
      man_fn <= i[2] ? fn_dbl_div_sub : fn_dbl_div_add;
      man_op <= dr;
      @(posedge aclk);
      man_fn <= fn_nop;
      sm = i[2] ? {1'b0, dd} + {1'b0, ~dr} + 33'(!i[1]) : {1'b0, dd} + {1'b0, dr} + 33'(i[1]);
      rchk(NDU_OFS_ACC_HIGH, {sm[30:0], i[1]});
      rchk(NDU_OFS_ACC_LOW, {dl[30:0], sm[32]});
      rchk(NDU_OFS_WRITE_BUS, {sm[30:0], i[1]});
      rd(NDU_OFS_FLAGS);
      chk("link and shift out", 32'(i[1:0]), 32'(d[2:1]));
    end
    // one quotient word, 32 steps back to back
    dd = $urandom;
    dl = $urandom;
    dr = $urandom;
    wr(NDU_OFS_ACC_HIGH, dd);
    wr(NDU_OFS_ACC_LOW, dl);
    wr(NDU_OFS_FLAGS, 32'h4);
    @(posedge aclk);
    man_fn <= fn_dbl_div_add;
    man_op <= dr;
    repeat (32) @(posedge aclk);
    man_fn <= fn_nop;
    for (int i = 0; i < 32; i++) begin
      sm = {1'b0, dd} + {1'b0, dr} + 33'h1;
      dd = {sm[30:0], 1'b1};
      dl = {dl[30:0], sm[32]};
    end
    rchk(NDU_OFS_ACC_HIGH, dd);
    rchk(NDU_OFS_ACC_LOW, dl);
    $display("test double done");
    tally_and_finish();
  end
endmodule // nonrestoring_divide_unit_tb
